/* File: rtl/dsba_pkg.sv */
// constants and types shared by the data-space byte-lane access block
`default_nettype none
package dsba_pkg;
    localparam int ADDR_W        = 16;              // byte address width
    localparam int DATA_W        = 16;              // word width
    localparam int PAGE_W        = 8;               // page select width
    localparam int EXT_W         = ADDR_W + PAGE_W; // 24-bit extended range
    localparam int WORD_AW       = ADDR_W - 1;      // word index width
    localparam logic [ADDR_W-1:0] REG_SPACE_END = 16'h0FFF;
    localparam logic [ADDR_W-1:0] NEAR_END      = 16'h1FFF;
    localparam logic [ADDR_W-1:0] IMPL_END      = 16'hCFFF; // 52 Kbytes
    localparam int NEAR_FIELD_W  = 13;
    localparam logic [ADDR_W-1:0] BYTE_STEP     = 16'h0001;
    localparam logic [ADDR_W-1:0] WORD_STEP     = 16'h0002;
    localparam logic [DATA_W-1:0] ZERO_WORD     = 16'h0000;
    // how the core formed the read or write address
    typedef enum logic [1:0] {
        DSBA_MODE_NEAR,
        DSBA_MODE_DIRECT,
        DSBA_MODE_INDIRECT,
        DSBA_MODE_POSTINC
    } dsba_mode_t;
    // working-register update performed alongside the read
    typedef enum logic [1:0] {
        DSBA_WR_LOAD,
        DSBA_WR_SIGN_EXTEND,
        DSBA_WR_CLEAR_UPPER,
        DSBA_WR_NONE
    } dsba_wreg_op_t;
endpackage
`default_nettype wire

/* File: rtl/dsba_agu.sv */
// address generation unit: one instance for reads, one for writes
`default_nettype none
module dsba_agu (
    input  wire logic                        near_sel,
    input  wire logic                        postinc,
    input  wire logic                        byte_op,
    input  wire logic [dsba_pkg::NEAR_FIELD_W-1:0] near_field,
    input  wire logic [dsba_pkg::ADDR_W-1:0] direct_field,
    input  wire logic                        use_pointer,
    input  wire logic [dsba_pkg::ADDR_W-1:0] working_source_pointer,
    output logic      [dsba_pkg::ADDR_W-1:0] effective_byte_address,
    output logic      [dsba_pkg::ADDR_W-1:0] next_pointer
);
    // address source select: near field, direct field or pointer
    always_comb begin
        if (near_sel) begin
            effective_byte_address = {{(dsba_pkg::ADDR_W-dsba_pkg::NEAR_FIELD_W){1'b0}},
                                      near_field};
        end else if (use_pointer) begin
            effective_byte_address = working_source_pointer;
        end else begin
            effective_byte_address = direct_field;
        end
    end
    // post-increment scaled by operand size
    always_comb begin
        if (postinc) begin
            next_pointer = working_source_pointer +
                (byte_op ? dsba_pkg::BYTE_STEP : dsba_pkg::WORD_STEP);
        end else begin
            next_pointer = working_source_pointer;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/dsba_top.sv */
// data-space byte-lane access: decode, lanes, zero fill, misalign trap
`default_nettype none
module dsba_top #(
    parameter int RAM_WORDS = 24576
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    // read request from the core
    input  wire logic                        rd_req,
    input  wire logic                        rd_byte,
    input  wire logic                        rd_near_sel,
    input  wire logic                        rd_postinc,
    input  wire logic                        rd_use_pointer,
    input  wire logic [dsba_pkg::NEAR_FIELD_W-1:0] rd_near_field,
    input  wire logic [dsba_pkg::ADDR_W-1:0] rd_direct_field,
    input  wire logic [dsba_pkg::ADDR_W-1:0] rd_pointer,
    input  wire logic [dsba_pkg::PAGE_W-1:0] read_page_select,
    input  wire dsba_pkg::dsba_wreg_op_t     rd_wreg_op,
    input  wire logic [dsba_pkg::DATA_W-1:0] rd_wreg_old,
    // write request from the core
    input  wire logic                        wr_req,
    input  wire logic                        wr_byte,
    input  wire logic                        wr_near_sel,
    input  wire logic                        wr_postinc,
    input  wire logic                        wr_use_pointer,
    input  wire logic [dsba_pkg::NEAR_FIELD_W-1:0] wr_near_field,
    input  wire logic [dsba_pkg::ADDR_W-1:0] wr_direct_field,
    input  wire logic [dsba_pkg::ADDR_W-1:0] wr_pointer,
    input  wire logic [dsba_pkg::PAGE_W-1:0] write_page_select,
    input  wire logic [dsba_pkg::DATA_W-1:0] wr_data,
    // register space answer
    input  wire logic [dsba_pkg::DATA_W-1:0] sfr_rdata,
    input  wire logic                        sfr_hit,
    // results to the core
    output logic                             rd_valid,
    output logic      [dsba_pkg::DATA_W-1:0] rd_data,
    output logic      [dsba_pkg::DATA_W-1:0] rd_wreg_new,
    output logic      [dsba_pkg::ADDR_W-1:0] rd_next_pointer,
    output logic      [dsba_pkg::ADDR_W-1:0] wr_next_pointer,
    output logic      [dsba_pkg::EXT_W-1:0]  rd_ext_addr,
    output logic      [dsba_pkg::EXT_W-1:0]  wr_ext_addr,
    // register space write port and read word address
    output logic                             sfr_wr_lo,
    output logic                             sfr_wr_hi,
    output logic      [dsba_pkg::WORD_AW-1:0] sfr_waddr,
    output logic      [dsba_pkg::DATA_W-1:0] sfr_wdata,
    output logic      [dsba_pkg::WORD_AW-1:0] sfr_raddr,
    // exception logic
    output logic                             addr_error,
    output logic      [dsba_pkg::ADDR_W-1:0] addr_error_ea,
    output logic                             addr_error_is_write
);
    localparam int RAM_AW = $clog2(RAM_WORDS);
    localparam logic [dsba_pkg::ADDR_W-1:0] RAM_END =
        dsba_pkg::ADDR_W'(int'(dsba_pkg::REG_SPACE_END) + 2 * RAM_WORDS);

    logic [dsba_pkg::ADDR_W-1:0] rd_ea;
    logic [dsba_pkg::ADDR_W-1:0] wr_ea;
    logic [dsba_pkg::ADDR_W-1:0] rd_np;
    logic [dsba_pkg::ADDR_W-1:0] wr_np;

    // two independent generators, one per direction
    dsba_agu u_rd_agu (
        .near_sel               (rd_near_sel),
        .postinc                (rd_postinc),
        .byte_op                (rd_byte),
        .near_field             (rd_near_field),
        .direct_field           (rd_direct_field),
        .use_pointer            (rd_use_pointer),
        .working_source_pointer (rd_pointer),
        .effective_byte_address (rd_ea),
        .next_pointer           (rd_np)
    );
    dsba_agu u_wr_agu (
        .near_sel               (wr_near_sel),
        .postinc                (wr_postinc),
        .byte_op                (wr_byte),
        .near_field             (wr_near_field),
        .direct_field           (wr_direct_field),
        .use_pointer            (wr_use_pointer),
        .working_source_pointer (wr_pointer),
        .effective_byte_address (wr_ea),
        .next_pointer           (wr_np)
    );

    // ram as two byte-wide lanes sharing one word index
    logic [7:0] ram_lo [RAM_WORDS];
    logic [7:0] ram_hi [RAM_WORDS];

    // region decode on the byte address
    logic rd_in_sfr, rd_in_ram, wr_in_sfr, wr_in_ram;
    logic rd_mis, wr_mis;
    logic [RAM_AW-1:0] rd_ridx, wr_ridx;
    always_comb begin
        rd_in_sfr = rd_ea <= dsba_pkg::REG_SPACE_END;
        wr_in_sfr = wr_ea <= dsba_pkg::REG_SPACE_END;
        rd_in_ram = !rd_in_sfr && rd_ea <= RAM_END && rd_ea <= dsba_pkg::IMPL_END;
        wr_in_ram = !wr_in_sfr && wr_ea <= RAM_END && wr_ea <= dsba_pkg::IMPL_END;
        rd_ridx   = RAM_AW'((rd_ea - dsba_pkg::REG_SPACE_END - 16'h0001) >> 1);
        wr_ridx   = RAM_AW'((wr_ea - dsba_pkg::REG_SPACE_END - 16'h0001) >> 1);
        rd_mis    = rd_req && !rd_byte && rd_ea[0];
        wr_mis    = wr_req && !wr_byte && wr_ea[0];
    end

    // lane strobes: even address low lane, odd high lane; odd word write dropped
    logic wr_ok, lo_en, hi_en;
    logic [dsba_pkg::DATA_W-1:0] wdata_lanes;
    always_comb begin
        wr_ok = wr_req && !wr_mis;
        lo_en = wr_ok && (!wr_byte || !wr_ea[0]);
        hi_en = wr_ok && (!wr_byte || wr_ea[0]);
        wdata_lanes = wr_byte ? {wr_data[7:0], wr_data[7:0]} : wr_data;
    end

    // ram lane writes, one strobe per lane
    always_ff @(posedge clk) begin
        if (lo_en && wr_in_ram) begin
            ram_lo[wr_ridx] <= wdata_lanes[7:0];
        end
        if (hi_en && wr_in_ram) begin
            ram_hi[wr_ridx] <= wdata_lanes[15:8];
        end
    end

    // read word fetch and lane select, zero outside implemented space
    logic [dsba_pkg::DATA_W-1:0] word_rd, next_rd_data, next_wreg;
    always_comb begin
        if (rd_in_ram) begin
            word_rd = {ram_hi[rd_ridx], ram_lo[rd_ridx]};
        end else if (rd_in_sfr && sfr_hit) begin
            word_rd = sfr_rdata;
        end else begin
            word_rd = dsba_pkg::ZERO_WORD;
        end
        if (rd_byte) begin
            next_rd_data = {8'h00, rd_ea[0] ? word_rd[15:8] : word_rd[7:0]};
        end else begin
            next_rd_data = word_rd;
        end
        case (rd_wreg_op)
            dsba_pkg::DSBA_WR_LOAD:
                next_wreg = rd_byte ? {rd_wreg_old[15:8], next_rd_data[7:0]}
                                    : next_rd_data;
            dsba_pkg::DSBA_WR_SIGN_EXTEND:
                next_wreg = {{8{rd_wreg_old[7]}}, rd_wreg_old[7:0]};
            dsba_pkg::DSBA_WR_CLEAR_UPPER:
                next_wreg = {8'h00, rd_wreg_old[7:0]};
            default:
                next_wreg = rd_wreg_old;
        endcase
    end

    // registered outputs; error pulse only in the cycle after detection
    logic                        next_err, next_err_w;
    logic [dsba_pkg::ADDR_W-1:0] next_err_ea;
    always_comb begin
        next_err    = rd_mis || wr_mis;
        next_err_w  = wr_mis;
        next_err_ea = wr_mis ? wr_ea : (rd_mis ? rd_ea : addr_error_ea);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_valid            <= 1'b0;
            rd_data             <= dsba_pkg::ZERO_WORD;
            rd_wreg_new         <= dsba_pkg::ZERO_WORD;
            rd_next_pointer     <= '0;
            wr_next_pointer     <= '0;
            rd_ext_addr         <= '0;
            wr_ext_addr         <= '0;
            sfr_wr_lo           <= 1'b0;
            sfr_wr_hi           <= 1'b0;
            sfr_waddr           <= '0;
            sfr_wdata           <= dsba_pkg::ZERO_WORD;
            sfr_raddr           <= '0;
            addr_error          <= 1'b0;
            addr_error_ea       <= '0;
            addr_error_is_write <= 1'b0;
        end else begin
            rd_valid            <= rd_req; // misaligned read still completes
            rd_data             <= next_rd_data;
            rd_wreg_new         <= next_wreg;
            rd_next_pointer     <= rd_np;
            wr_next_pointer     <= wr_np;
            rd_ext_addr         <= {read_page_select, rd_ea};
            wr_ext_addr         <= {write_page_select, wr_ea};
            sfr_wr_lo           <= lo_en && wr_in_sfr;
            sfr_wr_hi           <= hi_en && wr_in_sfr;
            sfr_waddr           <= wr_ea[dsba_pkg::ADDR_W-1:1];
            sfr_wdata           <= wdata_lanes;
            sfr_raddr           <= rd_ea[dsba_pkg::ADDR_W-1:1];
            addr_error          <= next_err;
            addr_error_ea       <= next_err_ea;
            addr_error_is_write <= next_err_w;
        end
    end

    // checks
    property p_err_pulse;
        @(posedge clk) disable iff (rst)
        (rd_req && !rd_byte && rd_ea[0]) |=> addr_error;
    endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("odd word read without error");
    property p_no_err;
        @(posedge clk) disable iff (rst)
        !((rd_req && !rd_byte && rd_ea[0]) || (wr_req && !wr_byte && wr_ea[0]))
            |=> !addr_error;
    endproperty
    a_no_err: assert property (p_no_err) else $error("spurious address error");
    property p_wr_supp;
        @(posedge clk) disable iff (rst)
        (wr_req && !wr_byte && wr_ea[0]) |=> !sfr_wr_lo && !sfr_wr_hi && addr_error_is_write;
    endproperty
    a_wr_supp: assert property (p_wr_supp) else $error("misaligned write not suppressed");
    property p_byte_lane;
        @(posedge clk) disable iff (rst)
        (wr_req && wr_byte && wr_in_sfr) |=> (sfr_wr_lo != sfr_wr_hi);
    endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("byte write hit both lanes");
    property p_byte_rd;
        @(posedge clk) disable iff (rst)
        (rd_req && rd_byte) |=> rd_data[15:8] == 8'h00;
    endproperty
    a_byte_rd: assert property (p_byte_rd) else $error("byte read upper lane not zero");
    property p_zero_out;
        @(posedge clk) disable iff (rst)
        (rd_req && rd_ea > dsba_pkg::IMPL_END) |=> rd_data == dsba_pkg::ZERO_WORD;
    endproperty
    a_zero_out: assert property (p_zero_out) else $error("unimplemented read not zero");
    property p_page;
        @(posedge clk) disable iff (rst)
        1'b1 |=> rd_ext_addr == {$past(read_page_select), $past(rd_ea)};
    endproperty
    a_page: assert property (p_page) else $error("extended read address wrong");
    property p_step;
        @(posedge clk) disable iff (rst)
        (rd_postinc && !rd_byte) |=> rd_next_pointer == $past(rd_pointer) + 16'h0002;
    endproperty
    a_step: assert property (p_step) else $error("word post-increment step wrong");
    property p_load_hi;
        @(posedge clk) disable iff (rst)
        (rd_byte && rd_wreg_op == dsba_pkg::DSBA_WR_LOAD) |=>
            rd_wreg_new[15:8] == $past(rd_wreg_old[15:8]);
    endproperty
    a_load_hi: assert property (p_load_hi) else $error("byte load touched high byte");
    property p_wr_both;
        @(posedge clk) disable iff (rst)
        (wr_req && !wr_byte && !wr_ea[0] && wr_in_sfr) |=> sfr_wr_lo && sfr_wr_hi;
    endproperty
    a_wr_both: assert property (p_wr_both) else $error("aligned word write missed a lane");
    property p_err_wr_ea;
        @(posedge clk) disable iff (rst)
        wr_mis |=> addr_error_ea == $past(wr_ea);
    endproperty
    a_err_wr_ea: assert property (p_err_wr_ea) else $error("write fault address wrong");
    property p_err_rd_ea;
        @(posedge clk) disable iff (rst)
        (rd_mis && !wr_mis) |=> !addr_error_is_write && addr_error_ea == $past(rd_ea);
    endproperty
    a_err_rd_ea: assert property (p_err_rd_ea) else $error("read fault address wrong");
    property p_byte_step;
        @(posedge clk) disable iff (rst)
        (rd_postinc && rd_byte) |=> rd_next_pointer == $past(rd_pointer) + dsba_pkg::BYTE_STEP;
    endproperty
    a_byte_step: assert property (p_byte_step) else $error("byte post-increment step wrong");
    property p_sign_ext;
        @(posedge clk) disable iff (rst)
        (rd_wreg_op == dsba_pkg::DSBA_WR_SIGN_EXTEND) |=>
            rd_wreg_new == {{8{$past(rd_wreg_old[7])}}, $past(rd_wreg_old[7:0])};
    endproperty
    a_sign_ext: assert property (p_sign_ext) else $error("sign extension wrong");
    property p_rd_done;
        @(posedge clk) disable iff (rst)
        1'b1 |=> rd_valid == $past(rd_req);
    endproperty
    a_rd_done: assert property (p_rd_done) else $error("read completion pulse wrong");
    property p_wr_page;
        @(posedge clk) disable iff (rst)
        1'b1 |=> wr_ext_addr == {$past(write_page_select), $past(wr_ea)};
    endproperty
    a_wr_page: assert property (p_wr_page) else $error("extended write address wrong");
    property p_near_zero;
        @(posedge clk) disable iff (rst)
        rd_near_sel |=> rd_ext_addr[dsba_pkg::ADDR_W-1:dsba_pkg::NEAR_FIELD_W] == '0;
    endproperty
    a_near_zero: assert property (p_near_zero) else $error("near address above 8 Kbytes");
    c_zero_rd: cover property (@(posedge clk) disable iff (rst)
        rd_req && !rd_in_ram && !rd_in_sfr);
    c_mis_rd: cover property (@(posedge clk) disable iff (rst) rd_mis);
    c_mis_wr: cover property (@(posedge clk) disable iff (rst) wr_mis);
    c_byte_hi: cover property (@(posedge clk) disable iff (rst) wr_req && wr_byte && wr_ea[0]);
    c_ram_rd: cover property (@(posedge clk) disable iff (rst) rd_req && rd_in_ram);
endmodule
`default_nettype wire

/* File: dv/dsba_sfr_model.sv */
// register-space partner: a few implemented words, a floating pattern elsewhere
`default_nettype none
module dsba_sfr_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [14:0] raddr,
    input  wire logic        sfr_wr_lo,
    input  wire logic        sfr_wr_hi,
    input  wire logic [14:0] sfr_waddr,
    input  wire logic [15:0] sfr_wdata,
    output logic      [15:0] sfr_rdata,
    output logic             sfr_hit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] regs [16];
    // only words 0x0000..0x000F exist; unused words float, so show a nonzero pattern
    always_comb begin
        sfr_hit = (raddr < 15'h0010);
        sfr_rdata = sfr_hit ? regs[raddr[3:0]] : {1'b1, ~raddr};
    end
    // one shared word address, a separate strobe per lane
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) begin
                regs[i] <= 16'h0000;
            end
        end else if (sfr_waddr < 15'h0010) begin
            if (sfr_wr_lo) regs[sfr_waddr[3:0]][7:0] <= sfr_wdata[7:0];
            if (sfr_wr_hi) regs[sfr_waddr[3:0]][15:8] <= sfr_wdata[15:8];
        end
    end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the data-space byte-lane access block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, rd_req, rd_byte, rd_near_sel, rd_postinc, rd_use_pointer;
    logic        wr_req, wr_byte, wr_near_sel, wr_postinc, wr_use_pointer, sfr_hit;
    logic        rd_valid, sfr_wr_lo, sfr_wr_hi, addr_error, addr_error_is_write;
    logic [12:0] rd_near_field, wr_near_field;
    logic [15:0] rd_direct_field, rd_pointer, rd_wreg_old, wr_direct_field, wr_pointer;
    logic [15:0] wr_data, sfr_rdata, rd_data, rd_wreg_new, rd_next_pointer, wr_next_pointer;
    logic [15:0] sfr_wdata, addr_error_ea;
    logic [7:0]  read_page_select, write_page_select;
    logic [23:0] rd_ext_addr, wr_ext_addr;
    logic [14:0] sfr_waddr, sfr_raddr, model_raddr;
    dsba_pkg::dsba_wreg_op_t rd_wreg_op;
    int          err_count, compares;

    dsba_top u_dut (.clk, .rst, .rd_req, .rd_byte, .rd_near_sel, .rd_postinc, .rd_use_pointer,
        .rd_near_field, .rd_direct_field, .rd_pointer, .read_page_select, .rd_wreg_op,
        .rd_wreg_old, .wr_req, .wr_byte, .wr_near_sel, .wr_postinc, .wr_use_pointer,
        .wr_near_field, .wr_direct_field, .wr_pointer, .write_page_select, .wr_data,
        .sfr_rdata, .sfr_hit, .rd_valid, .rd_data, .rd_wreg_new, .rd_next_pointer,
        .wr_next_pointer, .rd_ext_addr, .wr_ext_addr, .sfr_wr_lo, .sfr_wr_hi, .sfr_waddr,
        .sfr_wdata, .sfr_raddr, .addr_error, .addr_error_ea, .addr_error_is_write);
    // the partner must answer the read word in the request cycle itself
    assign model_raddr = rd_near_sel ? {3'h0, rd_near_field[12:1]} :
                         rd_use_pointer ? rd_pointer[15:1] : rd_direct_field[15:1];
    dsba_sfr_model u_sfr (.clk, .rst, .raddr(model_raddr), .sfr_wr_lo, .sfr_wr_hi,
        .sfr_waddr, .sfr_wdata, .sfr_rdata, .sfr_hit);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (err_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // one request cycle; f = {rd_req, rd_byte, wr_req, wr_byte}, results settle at the next fall
    task automatic access(input logic [3:0] f, input logic [15:0] ra, input logic [15:0] wa,
                          input logic [15:0] wd);
        {rd_req, rd_byte, wr_req, wr_byte} = f;
        {rd_direct_field, rd_pointer, rd_near_field} = {ra, ra, ra[12:0]};
        {wr_direct_field, wr_pointer, wr_near_field, wr_data} = {wa, wa, wa[12:0], wd};
        @(negedge clk);
    endtask
    // one cycle with both requests low: pulses fall, registered strobes land
    task automatic idle_cycle();
        {rd_req, wr_req} = 2'b00;
        @(negedge clk);
    endtask
    task automatic t_ram();
        access(4'h2, 16'h0, 16'h1000, 16'hBEEF);
        chk({sfr_wr_lo, sfr_wr_hi}, 32'h0);
        chk(wr_ext_addr, 32'hC31000);
        access(4'hA, 16'h1000, 16'hCFFE, 16'h1234);
        chk({rd_valid, rd_data}, 32'h1BEEF);
        chk(rd_ext_addr, 32'h5A1000);
        access(4'hA, 16'hCFFE, 16'hD000, 16'h7777);
        chk(rd_data, 32'h1234);
        access(4'h8, 16'hD000, 16'h0, 16'h0);
        chk(rd_data, 32'h0);
    endtask
    task automatic t_lanes();
        access(4'h3, 16'h0, 16'h1001, 16'h0012);
        chk(addr_error, 32'h0);
        access(4'h8, 16'h1000, 16'h0, 16'h0);
        chk(rd_data, 32'h12EF);
        access(4'hC, 16'h1000, 16'h0, 16'h0);
        chk(rd_data, 32'h00EF);
        access(4'hF, 16'h1001, 16'h1000, 16'h0034);
        chk(rd_data, 32'h0012);
        access(4'h8, 16'h1000, 16'h0, 16'h0);
        chk(rd_data, 32'h1234);
    endtask
    task automatic t_sfr();
        access(4'h3, 16'h0, 16'h0003, 16'h005C);
        chk({sfr_wr_lo, sfr_wr_hi, sfr_waddr}, {2'b01, 15'h0001});
        chk(sfr_wdata[15:8], 32'h5C);
        // lane strobes are registered, so the register write lands one cycle later
        idle_cycle();
        access(4'h8, 16'h0002, 16'h0, 16'h0);
        chk(rd_data, 32'h5C00);
        access(4'hC, 16'h0003, 16'h0, 16'h0);
        chk(rd_data, 32'h005C);
        chk(sfr_raddr, 32'h1);
        access(4'h8, 16'h0800, 16'h0004, 16'h0);
        chk(rd_data, 32'h0);
        access(4'h2, 16'h0, 16'h0004, 16'hA55A);
        chk({sfr_wr_lo, sfr_wr_hi}, 32'h3);
    endtask
    // odd word accesses: the write is dropped, the read completes, one error per cycle, the write's address when both are odd
    task automatic t_misalign();
        access(4'h2, 16'h0, 16'h1002, 16'h4444);
        access(4'h2, 16'h0, 16'h1003, 16'h9999);
        chk({addr_error, addr_error_is_write, addr_error_ea}, 32'h31003);
        access(4'hA, 16'h1002, 16'h0005, 16'h9999);
        chk({sfr_wr_lo, sfr_wr_hi, addr_error, rd_data}, 32'h14444);
        access(4'h8, 16'h1001, 16'h0, 16'h0);
        chk({rd_valid, addr_error, addr_error_is_write, addr_error_ea}, {3'b110, 16'h1001});
        access(4'hA, 16'h1001, 16'h1003, 16'h0);
        chk({addr_error, addr_error_ea}, 32'h11003);
        idle_cycle();
        chk({rd_valid, addr_error}, 32'h0);
    endtask
    task automatic t_modes();
        {rd_use_pointer, rd_postinc, wr_use_pointer, wr_postinc} = 4'hF;
        access(4'hF, 16'h1000, 16'h1004, 16'h0056);
        chk({rd_next_pointer, rd_data}, 32'h10010034);
        chk(wr_next_pointer, 32'h1005);
        access(4'hA, 16'h1000, 16'h1004, 16'h0);
        chk({rd_next_pointer, wr_next_pointer}, 32'h10021006);
        chk({rd_ext_addr, rd_data[7:0]}, 32'h5A100034);
        {rd_postinc, wr_postinc, rd_near_sel, wr_near_sel} = 4'b0011;
        access(4'hA, 16'h3000, 16'h3002, 16'h0);
        chk({rd_next_pointer, rd_data}, 32'h30001234);
        chk(rd_ext_addr, 32'h5A1000);
        chk(wr_ext_addr, 32'hC31002);
        {rd_use_pointer, wr_use_pointer, rd_near_sel, wr_near_sel} = 4'b0000;
    endtask
    task automatic t_wreg();
        dsba_pkg::dsba_wreg_op_t op [5] = '{dsba_pkg::DSBA_WR_LOAD,
            dsba_pkg::DSBA_WR_SIGN_EXTEND, dsba_pkg::DSBA_WR_SIGN_EXTEND,
            dsba_pkg::DSBA_WR_CLEAR_UPPER, dsba_pkg::DSBA_WR_NONE};
        logic [15:0] old [5] = '{16'hAB00, 16'h1280, 16'hAB7F, 16'hAB80, 16'hAB80};
        logic [15:0] exp [5] = '{16'hAB12, 16'hFF80, 16'h007F, 16'h0080, 16'hAB80};
        for (int i = 0; i < 5; i++) begin
            rd_wreg_op = op[i];
            rd_wreg_old = old[i];
            access(4'hC, 16'h1001, 16'h0, 16'h0);
            chk(rd_wreg_new, exp[i]);
        end
    endtask
    // hang guard: the whole run needs well under a hundred cycles
    initial begin
        repeat (2000) @(posedge clk);
        err_count++;
        final_report();
    end
    initial begin
        {err_count, compares, rst} = {32'h0, 32'h0, 1'b1};
        {rd_req, rd_byte, rd_near_sel, rd_postinc, rd_use_pointer} = 5'h00;
        {wr_req, wr_byte, wr_near_sel, wr_postinc, wr_use_pointer} = 5'h00;
        {rd_near_field, rd_direct_field, rd_pointer, rd_wreg_old} = '0;
        {wr_near_field, wr_direct_field, wr_pointer, wr_data} = '0;
        {read_page_select, write_page_select} = 16'h5AC3;
        rd_wreg_op = dsba_pkg::DSBA_WR_NONE;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk({rd_valid, addr_error, sfr_wr_lo, sfr_wr_hi}, 32'h0);
        t_ram();
        t_lanes();
        t_sfr();
        t_misalign();
        t_modes();
        t_wreg();
        final_report();
    end
endmodule
`default_nettype wire
